// >>> pcsp_consts.svh
// constants for the parity core store port: sizes, field positions, timing
`ifndef PCSP_CONSTS_SVH
`define PCSP_CONSTS_SVH

// number of store interface links: processor plus three io processors
`define PCSP_LINKS 4
`define PCSP_ADDR_W 16
`define PCSP_DATA_W 16
// sixteen data bits plus one parity bit per byte
`define PCSP_WORD_W 18
`define PCSP_PAR_HI 17
`define PCSP_PAR_LO 16
// halfword index width and depth at full 64 kilobyte capacity
`define PCSP_IDX_W 15
`define PCSP_DEPTH 32768
// capacity in kilobytes, base module and with expansion unit
`define PCSP_BASE_KB 32
`define PCSP_FULL_KB 64
// nominal store cycle and clock period in nanoseconds
`define PCSP_CYCLE_NS 550
`define PCSP_CLK_NS 100
// longest time, so rounded down to whole clock cycles
`define PCSP_STORE_CYCLES (`PCSP_CYCLE_NS / `PCSP_CLK_NS)
// link index that belongs to the central processor
`define PCSP_CPU_LINK 0

`endif

// >>> pcsp_pkg.sv
// types for the parity core store port
`default_nettype none
`include "pcsp_consts.svh"

package pcsp_pkg;

  // access sequencer states
  typedef enum logic [1:0] {
    PCSP_IDLE = 2'b00,
    PCSP_BUSY = 2'b01,
    PCSP_DONE = 2'b10
  } pcsp_state_t;

  // all control state of the store port
  typedef struct packed {
    pcsp_state_t state;
    logic [2:0] cnt;
    logic [1:0] link;
    logic wr;
    logic half;
    logic lane;
    logic [`PCSP_WORD_W-1:0] word;
    logic [`PCSP_LINKS-1:0] ack;
    logic [`PCSP_LINKS-1:0][`PCSP_DATA_W-1:0] rdata;
    logic [`PCSP_LINKS-1:0] perr;
    logic cpu_fail;
    logic lamp;
    logic exp_s1;
    logic exp_s2;
    logic clr_s1;
    logic clr_s2;
  } pcsp_st_t;

endpackage
`default_nettype wire

// >>> pcsp_director.sv
// store access director: fixed priority choice among link requests
`timescale 1ns/10ps
`default_nettype none
`include "pcsp_consts.svh"

module pcsp_director (
  input wire logic [`PCSP_LINKS-1:0] req,
  input wire logic [`PCSP_LINKS-1:0] mask,
  output logic gnt_valid,
  output logic [1:0] gnt_idx
);

  logic [`PCSP_LINKS-1:0] live;

  // lowest index wins
  // links 0 and 1 under constant load can starve links 2 and 3, since the store masks only the link just answered
  always_comb begin
    live = req & ~mask;
    gnt_valid = 1'b0;
    gnt_idx = 2'h0;
    for (int i = `PCSP_LINKS - 1; i >= 0; i--) begin
      if (live[i]) begin
        gnt_valid = 1'b1;
        gnt_idx = 2'(i);
      end
    end
  end

endmodule
`default_nettype wire

// >>> pcsp_store.sv
// parity core store port: store, director, parity generation and check
`timescale 1ns/10ps
`default_nettype none
`include "pcsp_consts.svh"

module pcsp_store (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [`PCSP_LINKS-1:0] LINK_REQ,
  input wire logic [`PCSP_LINKS-1:0] LINK_WRITE,
  input wire logic [`PCSP_LINKS-1:0] LINK_HALF,
  input wire logic [`PCSP_LINKS-1:0][`PCSP_ADDR_W-1:0] LINK_ADDR,
  input wire logic [`PCSP_LINKS-1:0][`PCSP_DATA_W-1:0] LINK_WDATA,
  input wire logic EXPANSION_FITTED,
  input wire logic LAMP_CLEAR,
  output logic [`PCSP_LINKS-1:0] LINK_ACK,
  output logic [`PCSP_LINKS-1:0][`PCSP_DATA_W-1:0] LINK_RDATA,
  output logic [`PCSP_LINKS-1:0] LINK_PERR,
  output logic CPU_PARITY_FAIL,
  output logic PARITY_LAMP
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // odd parity: a zero byte stores a one, so an all-zero word reads as bad
  // one function serves the write side and the read check alike
  function automatic logic par_of(input logic [7:0] b);
    par_of = ~(^b);
  endfunction

  // halfword index; without the expansion unit the top half folds onto the bottom
  function automatic logic [`PCSP_IDX_W-1:0] word_index(input logic [`PCSP_ADDR_W-1:0] a, input logic full);
    word_index = {a[15] & full, a[14:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage and state

  localparam logic [2:0] CYC_LOAD = 3'(`PCSP_STORE_CYCLES - 1);

  // the array is not reset: core keeps its contents without power, so a word
  // never written reads back unknown and its parity check means nothing
  // sixteen data bits and two parity bits per word
  logic [`PCSP_WORD_W-1:0] mem [0:`PCSP_DEPTH-1];
  pcsp_pkg::pcsp_st_t st_r;
  pcsp_pkg::pcsp_st_t st_nxt;
  logic [`PCSP_LINKS-1:0] mask;
  logic gnt_valid;
  logic [1:0] gnt_idx;
  logic take;
  logic [`PCSP_ADDR_W-1:0] g_addr;
  logic [`PCSP_DATA_W-1:0] g_wdata;
  logic g_half;
  logic g_lane;
  logic [`PCSP_IDX_W-1:0] g_idx;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  logic bad_hi;
  logic bad_lo;
  logic bad;

  ////////////////////////////////////////////////////////////////////////////
  // director

  // four links; the link just answered is masked for one cycle
  assign mask = (st_r.state == pcsp_pkg::PCSP_DONE) ? 4'(1 << st_r.link) : 4'h0;

  // the director only sees request lines and the mask; the sequencer decides whether its
  // choice is taken, so a losing or blocked link simply keeps asking
  pcsp_director pcsp_director_inst (
    .req(LINK_REQ),
    .mask(mask),
    .gnt_valid(gnt_valid),
    .gnt_idx(gnt_idx)
  );

  // selected link's request fields
  assign take = gnt_valid && (st_r.state != pcsp_pkg::PCSP_BUSY);
  assign g_addr = LINK_ADDR[gnt_idx];
  assign g_wdata = LINK_WDATA[gnt_idx];
  assign g_half = LINK_HALF[gnt_idx];
  assign g_lane = g_addr[0];
  assign g_idx = word_index(g_addr, st_r.exp_s2);
  // a byte write takes its data from the low lane
  assign hi_byte = g_half ? g_wdata[15:8] : g_wdata[7:0];
  assign lo_byte = g_wdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // core array write

  // each written byte stores its own parity, the other byte is untouched
  // the write lands at the take edge; the answer still waits out the store cycle
  // plain clocked process, not always_ff, so a bench may plant a bad parity bit
  always @(posedge MCLK) begin
    if (take && LINK_WRITE[gnt_idx]) begin
      if (g_half || !g_lane) begin
        mem[g_idx][15:8] <= hi_byte;
        mem[g_idx][`PCSP_PAR_HI] <= par_of(hi_byte);
      end
      if (g_half || g_lane) begin
        mem[g_idx][7:0] <= lo_byte;
        mem[g_idx][`PCSP_PAR_LO] <= par_of(lo_byte);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity check of the captured word

  // only the bytes actually returned are judged
  // a byte read never reports a fault in the byte it did not return
  always_comb begin
    bad_hi = par_of(st_r.word[15:8]) != st_r.word[`PCSP_PAR_HI];
    bad_lo = par_of(st_r.word[7:0]) != st_r.word[`PCSP_PAR_LO];
    if (st_r.half) begin
      bad = bad_hi | bad_lo;
    end else begin
      bad = st_r.lane ? bad_lo : bad_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // sequencer, strap and panel synchronisers, lamp
  // take at edge 0, answer flops set at edge 4, then one rest cycle: one access
  // every five clocks, 500 ns against the 550 ns nominal store cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = '0;
    st_nxt.perr = '0;
    st_nxt.cpu_fail = 1'b0;
    // strap and panel lines are asynchronous to the store clock, so each
    // passes two flops before anything reads it
    // expansion strap, first flop feeds only the second
    st_nxt.exp_s1 = EXPANSION_FITTED;
    st_nxt.exp_s2 = st_r.exp_s1;
    st_nxt.clr_s1 = LAMP_CLEAR;
    st_nxt.clr_s2 = st_r.clr_s1;
    if (st_r.clr_s2) begin
      st_nxt.lamp = 1'b0;
    end
    case (st_r.state)
      pcsp_pkg::PCSP_BUSY: begin
        // answer four cycles after the take, next take one later
        if (st_r.cnt == 3'h1) begin
          st_nxt.state = pcsp_pkg::PCSP_DONE;
          st_nxt.ack[st_r.link] = 1'b1;
          if (!st_r.wr) begin
            // byte reads come back in the low lane
            if (st_r.half) begin
              st_nxt.rdata[st_r.link] = st_r.word[15:0];
            end else begin
              st_nxt.rdata[st_r.link] = {8'h00, st_r.lane ? st_r.word[7:0] : st_r.word[15:8]};
            end
            st_nxt.perr[st_r.link] = bad;
            // processor told of any failure, lamp set beats clear
            st_nxt.cpu_fail = bad;
            if (bad) begin
              st_nxt.lamp = 1'b1;
            end
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      pcsp_pkg::PCSP_DONE: begin
        // one rest cycle: the answered link is masked, any other may be taken
        st_nxt.state = pcsp_pkg::PCSP_IDLE;
      end
      pcsp_pkg::PCSP_IDLE: begin
        st_nxt.state = pcsp_pkg::PCSP_IDLE;
      end
      default: begin
        // unused code falls back to idle
        st_nxt.state = pcsp_pkg::PCSP_IDLE;
      end
    endcase
    // one link taken per store cycle, losers keep waiting
    if (take) begin
      st_nxt.state = pcsp_pkg::PCSP_BUSY;
      st_nxt.cnt = CYC_LOAD;
      st_nxt.link = gnt_idx;
      st_nxt.wr = LINK_WRITE[gnt_idx];
      st_nxt.half = g_half;
      st_nxt.lane = g_lane;
      st_nxt.word = mem[g_idx];
    end
  end

  // registered state, synchronous reset
  // every state flop is reset, lamp and synchronisers included; the array keeps its contents
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  // every pin comes straight from the state flops, so the far side sees no
  // combinational path from its own request lines back to its answer lines
  assign LINK_ACK = st_r.ack;
  assign LINK_RDATA = st_r.rdata;
  assign LINK_PERR = st_r.perr;
  assign CPU_PARITY_FAIL = st_r.cpu_fail;
  assign PARITY_LAMP = st_r.lamp;

endmodule
`default_nettype wire

// >>> pcsp_req_model.sv
// requester model for the four store links
`timescale 1ns/10ps
`default_nettype none
`include "pcsp_consts.svh"
module pcsp_req_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`PCSP_LINKS-1:0] go,
  input wire logic [`PCSP_LINKS-1:0] ack,
  output logic [`PCSP_LINKS-1:0] req
);
  // loser keeps asking
  // request held until its own ack, dropped in the cycle after it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req <= 4'h0;
    end else begin
      req <= (req & ~ack) | go;
    end
  end
endmodule
`default_nettype wire

// >>> pcsp_store_props.sv
// pin level checks of the store port
`timescale 1ns/10ps
`default_nettype none
`include "pcsp_consts.svh"
module pcsp_store_props (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [`PCSP_LINKS-1:0] LINK_REQ,
  input wire logic [`PCSP_LINKS-1:0] LINK_WRITE,
  input wire logic [`PCSP_LINKS-1:0] LINK_ACK,
  input wire logic [`PCSP_LINKS-1:0][`PCSP_DATA_W-1:0] LINK_RDATA,
  input wire logic [`PCSP_LINKS-1:0] LINK_PERR,
  input wire logic CPU_PARITY_FAIL,
  input wire logic PARITY_LAMP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  one_grant_a: assert property ($onehot0(LINK_ACK))
    else $error("two acks");
  ack_pulse_a: assert property (|LINK_ACK |=> LINK_ACK == 4'h0)
    else $error("ack too long");
  ack_cause_a: assert property ((LINK_ACK & ~$past(LINK_REQ, 4)) == 4'h0)
    else $error("ack without request");
  // worst case waits out one access ahead
  ack_time_a: assert property ($rose(LINK_REQ[0]) |-> ##[4:10] LINK_ACK[0])
    else $error("slow ack");
  perr_ack_a: assert property ((LINK_PERR & ~LINK_ACK) == 4'h0)
    else $error("perr off ack");
  cpu_fail_a: assert property (CPU_PARITY_FAIL == (|LINK_PERR))
    else $error("cpu fail mismatch");
  lamp_set_a: assert property (|LINK_PERR |-> PARITY_LAMP)
    else $error("lamp not lit");
  rdata_cause_a: assert property ($changed(LINK_RDATA) |-> |(LINK_ACK & ~LINK_WRITE))
    else $error("rdata moved");
  cover property (LINK_ACK[3]);
  cover property (LINK_ACK[1] && LINK_REQ[2]);
  cover property (LINK_ACK[0] && LINK_WRITE[0]);
  cover property (|LINK_PERR && PARITY_LAMP);
endmodule
bind pcsp_store pcsp_store_props pcsp_store_props_inst (.MCLK, .RST_B, .LINK_REQ, .LINK_WRITE,
  .LINK_ACK, .LINK_RDATA, .LINK_PERR, .CPU_PARITY_FAIL, .PARITY_LAMP);
`default_nettype wire

// >>> pcsp_store_bench.sv
// self-checking bench for the store port
`timescale 1ns/10ps
`default_nettype none
`include "pcsp_consts.svh"
module pcsp_store_bench;
  logic mclk, rst_b, expn, lclr, cpu_fail, lamp;
  logic [3:0] go, req, wr, half, ack, perr;
  logic [3:0][15:0] addr, wdata, rdata;
  int fail_count, n_tests;
  logic [1:0] exp_flags;
  pcsp_store pcsp_store_inst (.MCLK(mclk), .RST_B(rst_b), .LINK_REQ(req), .LINK_WRITE(wr), .LINK_HALF(half),
    .LINK_ADDR(addr), .LINK_WDATA(wdata), .EXPANSION_FITTED(expn), .LAMP_CLEAR(lclr), .LINK_ACK(ack),
    .LINK_RDATA(rdata), .LINK_PERR(perr), .CPU_PARITY_FAIL(cpu_fail), .PARITY_LAMP(lamp));
  pcsp_req_model pcsp_req_model_inst (.clk(mclk), .rst_b(rst_b), .go(go), .ack(ack), .req(req));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access on an idle store; sampled at negedge so the ack edge has settled
  task automatic acc(input int l, input logic w, input logic h, input logic [15:0] a, input logic [15:0] d,
    output logic [15:0] r);
    int n;
    @(posedge mclk);
    wr[l] <= w;
    half[l] <= h;
    addr[l] <= a;
    wdata[l] <= d;
    go[l] <= 1'b1;
    @(posedge mclk);
    go[l] <= 1'b0;
    n = 0;
    while (ack[l] !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      final_report();
    end
    chk("latency", 16'h0006, 16'(n));
    chk("parity flags", {14'h0, exp_flags}, {14'h0, perr[l], cpu_fail});
    r = rdata[l];
  endtask
  ////////////////////////////////////////
  task automatic s_data();
    logic [15:0] r;
    acc(0, 1'b1, 1'b1, 16'h0010, 16'hA55A, r);
    acc(0, 1'b0, 1'b1, 16'h0010, 16'h0000, r);
    chk("half read", 16'hA55A, r);
    acc(2, 1'b1, 1'b0, 16'h0011, 16'hFF3C, r);
    acc(2, 1'b0, 1'b1, 16'h0010, 16'h0000, r);
    chk("byte merge", 16'hA53C, r);
    acc(3, 1'b0, 1'b0, 16'h0010, 16'h0000, r);
    chk("byte high", 16'h00A5, r);
  endtask
  // all four links at once: fixed order, one grant per access
  task automatic s_prio();
    int n, k;
    logic [15:0] ord;
    @(posedge mclk);
    wr <= 4'h0;
    half <= 4'hF;
    addr <= {4{16'h0010}};
    go <= 4'hF;
    @(posedge mclk);
    go <= 4'h0;
    ord = 16'h0000;
    k = 0;
    n = 0;
    while (k < 4 && n < 60) begin
      @(negedge mclk);
      n++;
      if (ack != 4'h0) begin
        ord = {ord[11:0], ack};
        k++;
      end
    end
    if (k < 4) begin
      fail_count++;
      final_report();
    end
    chk("grant order", 16'h1248, ord);
    chk("io link data", 16'hA53C, rdata[3]);
  endtask
  // upper half aliases until the expansion strap is seen
  task automatic s_cap();
    logic [15:0] r;
    acc(1, 1'b1, 1'b1, 16'h8020, 16'h1234, r);
    acc(1, 1'b0, 1'b1, 16'h0020, 16'h0000, r);
    chk("alias", 16'h1234, r);
    @(posedge mclk);
    expn <= 1'b1;
    lclr <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1, 1'b1, 1'b1, 16'h0020, 16'h5678, r);
    acc(1, 1'b1, 1'b1, 16'h8020, 16'h9ABC, r);
    acc(1, 1'b0, 1'b1, 16'h0020, 16'h0000, r);
    chk("low half", 16'h5678, r);
    acc(1, 1'b0, 1'b1, 16'h8020, 16'h0000, r);
    chk("high half", 16'h9ABC, r);
  endtask
  // a parity bit planted bad in the array: only the returned bytes are judged
  task automatic s_fail();
    logic [15:0] r;
    @(posedge mclk);
    lclr <= 1'b0;
    repeat (3) @(posedge mclk);
    acc(2, 1'b1, 1'b1, 16'h0040, 16'h0301, r);
    chk("stored parity", 16'h0002, {14'h0, pcsp_store_inst.mem[32][`PCSP_PAR_HI:`PCSP_PAR_LO]});
    pcsp_store_inst.mem[32][`PCSP_PAR_HI] = ~pcsp_store_inst.mem[32][`PCSP_PAR_HI];
    acc(2, 1'b0, 1'b0, 16'h0041, 16'h0000, r);
    chk("good lane", 16'h0001, r);
    exp_flags = 2'b11;
    acc(2, 1'b0, 1'b1, 16'h0040, 16'h0000, r);
    exp_flags = 2'b00;
    chk("bad half data", 16'h0301, r);
    chk("lamp set", 16'h0001, {15'h0, lamp});
    repeat (3) @(negedge mclk);
    chk("lamp held", 16'h0001, {15'h0, lamp});
    @(posedge mclk);
    lclr <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("lamp clear", 16'h0000, {15'h0, lamp});
  endtask
  initial begin
    rst_b = 1'b0;
    expn = 1'b0;
    lclr = 1'b0;
    go = 4'h0;
    wr = 4'h0;
    half = 4'h0;
    addr = '0;
    wdata = '0;
    fail_count = 0;
    n_tests = 0;
    exp_flags = 2'b00;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    s_data();
    s_prio();
    s_cap();
    s_fail();
    chk("lamp", 16'h0000, {15'h0, lamp});
    final_report();
  end
endmodule
`default_nettype wire
